// *** verilog/ctb_core.sv ***
// Execution core for data transfer, bit and control instructions
`timescale 1ns/100ps
module ctb_core
    import ctb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire ctb_op_t instr_op,
    input wire logic [4:0] instr_reg,
    input wire logic [1:0] instr_ptr_sel,
    input wire logic [1:0] instr_ptr_mode,
    input wire logic [2:0] instr_bit,
    input wire logic [5:0] instr_disp,
    input wire logic [15:0] instr_addr,
    input wire logic [7:0] instr_imm,
    input wire logic ext_wr_en,
    input wire logic [7:0] ext_wr_data,
    output logic [15:0] dmem_addr,
    output logic dmem_re,
    output logic dmem_we,
    output logic [7:0] dmem_wdata,
    input wire logic [7:0] dmem_rdata,
    output logic [23:0] pmem_addr,
    output logic pmem_re,
    input wire logic [7:0] pmem_rdata,
    output logic [4:0] io_addr,
    output logic io_we,
    output logic [7:0] io_wdata,
    output logic [7:0] io_wmask,
    output logic sleep_req,
    output logic wdog_req,
    output logic [7:0] status,
    output logic [15:0] stack_ptr,
    output logic [7:0] ext_byte,
    input wire logic [4:0] peek_idx,
    output logic [7:0] peek_data
);

    // ==========================================================
    // Reset release
    logic rst_meta_reg;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    // ==========================================================
    // State
    ctb_state_t state_reg, state_next;
    ctb_op_t op_reg, op_next;
    logic [4:0] rd_reg, rd_next;
    logic [7:0] gpr_reg [0:31];
    logic [7:0] gpr_next [0:31];
    logic [7:0] stat_reg, stat_next;
    logic [15:0] sp_reg, sp_next;
    logic [7:0] ext_reg, ext_next;
    logic [15:0] dmem_addr_reg, dmem_addr_next;
    logic dmem_re_reg, dmem_re_next;
    logic dmem_we_reg, dmem_we_next;
    logic [7:0] dmem_wdata_reg, dmem_wdata_next;
    logic [23:0] pmem_addr_reg, pmem_addr_next;
    logic pmem_re_reg, pmem_re_next;
    logic [4:0] io_addr_reg, io_addr_next;
    logic io_we_reg, io_we_next;
    logic [7:0] io_wdata_reg, io_wdata_next;
    logic [7:0] io_wmask_reg, io_wmask_next;
    logic sleep_reg, sleep_next;
    logic wdog_reg, wdog_next;

    logic take;
    logic [4:0] ptr_base;
    logic [15:0] ptr_val;
    logic [15:0] ptr_dec;
    logic [23:0] wide_addr;
    logic [7:0] src_val;
    logic [7:0] bu_result;
    logic bu_c, bu_z, bu_n, bu_v, bu_t;

    assign take = instr_valid && (state_reg == ST_IDLE);
    assign ptr_base = (instr_ptr_sel == PTR_SEL_X) ? PTR_BASE_X :
                      (instr_ptr_sel == PTR_SEL_Y) ? PTR_BASE_Y : PTR_BASE_Z;
    assign ptr_val = {gpr_reg[ptr_base + 5'h01], gpr_reg[ptr_base]};
    assign ptr_dec = ptr_val - 16'h0001;
    assign wide_addr = {ext_reg, gpr_reg[PTR_BASE_Z + 5'h01], gpr_reg[PTR_BASE_Z]};
    assign src_val = gpr_reg[instr_reg];

    ctb_bit_unit u_bit_unit (
        .op(instr_op),
        .operand(src_val),
        .carry_in(stat_reg[STAT_C]),
        .t_in(stat_reg[STAT_T]),
        .bit_sel(instr_bit),
        .result(bu_result),
        .res_c(bu_c),
        .res_z(bu_z),
        .res_n(bu_n),
        .res_v(bu_v),
        .t_out(bu_t)
    );

    // ==========================================================
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        rd_next = rd_reg;
        gpr_next = gpr_reg;
        stat_next = stat_reg;
        sp_next = sp_reg;
        ext_next = ext_wr_en ? ext_wr_data : ext_reg;
        dmem_addr_next = dmem_addr_reg;
        dmem_re_next = 1'b0;
        dmem_we_next = 1'b0;
        dmem_wdata_next = dmem_wdata_reg;
        pmem_addr_next = pmem_addr_reg;
        pmem_re_next = 1'b0;
        io_addr_next = io_addr_reg;
        io_we_next = 1'b0;
        io_wdata_next = io_wdata_reg;
        io_wmask_next = io_wmask_reg;
        sleep_next = 1'b0;
        wdog_next = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    op_next = instr_op;
                    rd_next = instr_reg;
                    unique case (instr_op)
                        OP_LD_PTR, OP_ST_PTR: begin
                            state_next = ST_DONE;
                            dmem_re_next = (instr_op == OP_LD_PTR);
                            dmem_we_next = (instr_op == OP_ST_PTR);
                            dmem_wdata_next = src_val;
                            dmem_addr_next = ptr_val;
                            if (instr_ptr_mode == PTR_MODE_POSTINC) begin
                                {gpr_next[ptr_base + 5'h01], gpr_next[ptr_base]} = ptr_val + 16'h0001;
                            end else if (instr_ptr_mode == PTR_MODE_PREDEC) begin
                                dmem_addr_next = ptr_dec;
                                {gpr_next[ptr_base + 5'h01], gpr_next[ptr_base]} = ptr_dec;
                            end
                        end
                        OP_LD_DISP, OP_ST_DISP: begin
                            state_next = ST_DONE;
                            dmem_re_next = (instr_op == OP_LD_DISP);
                            dmem_we_next = (instr_op == OP_ST_DISP);
                            dmem_wdata_next = src_val;
                            dmem_addr_next = ptr_val + {10'h000, instr_disp};
                        end
                        OP_LD_DIRECT, OP_ST_DIRECT: begin
                            state_next = ST_DONE;
                            dmem_re_next = (instr_op == OP_LD_DIRECT);
                            dmem_we_next = (instr_op == OP_ST_DIRECT);
                            dmem_wdata_next = src_val;
                            dmem_addr_next = instr_addr;
                        end
                        OP_PMEM_RD, OP_PMEM_WIDE_RD: begin
                            state_next = ST_WAIT;
                            pmem_re_next = 1'b1;
                            if (instr_op == OP_PMEM_RD) begin
                                pmem_addr_next = {8'h00, wide_addr[15:0]};
                                if (instr_ptr_mode == PTR_MODE_POSTINC) begin
                                    {gpr_next[PTR_BASE_Z + 5'h01], gpr_next[PTR_BASE_Z]} = wide_addr[15:0] + 16'h0001;
                                end
                            end else begin
                                pmem_addr_next = wide_addr;
                                if (instr_ptr_mode == PTR_MODE_POSTINC) begin
                                    {ext_next, gpr_next[PTR_BASE_Z + 5'h01], gpr_next[PTR_BASE_Z]} =
                                        wide_addr + 24'h000001;
                                end
                            end
                        end
                        OP_IO_SET, OP_IO_CLR: begin
                            state_next = ST_DONE;
                            io_we_next = 1'b1;
                            io_addr_next = instr_addr[4:0];
                            io_wmask_next = 8'h01 << instr_bit;
                            io_wdata_next = (instr_op == OP_IO_SET) ? 8'hFF : 8'h00;
                        end
                        OP_PUSH: begin
                            state_next = ST_DONE;
                            dmem_we_next = 1'b1;
                            dmem_addr_next = sp_reg;
                            dmem_wdata_next = src_val;
                            sp_next = sp_reg - 16'h0001;
                        end
                        OP_POP: begin
                            state_next = ST_DONE;
                            dmem_re_next = 1'b1;
                            dmem_addr_next = sp_reg + 16'h0001;
                            sp_next = sp_reg + 16'h0001;
                        end
                        OP_LSL, OP_LSR, OP_ROL, OP_ROR: begin
                            gpr_next[instr_reg] = bu_result;
                            stat_next[STAT_C] = bu_c;
                            stat_next[STAT_Z] = bu_z;
                            stat_next[STAT_N] = bu_n;
                            stat_next[STAT_V] = bu_v;
                        end
                        OP_SWAP, OP_T_TO_BIT: gpr_next[instr_reg] = bu_result;
                        OP_BIT_TO_T: stat_next[STAT_T] = bu_t;
                        OP_FLAG_SET: stat_next[instr_bit] = 1'b1;
                        OP_FLAG_CLR: stat_next[instr_bit] = 1'b0;
                        OP_LDI: gpr_next[instr_reg] = instr_imm;
                        OP_SLEEP: sleep_next = 1'b1;
                        OP_WDOG: wdog_next = 1'b1;
                        default: state_next = ST_IDLE;
                    endcase
                end
            end
            ST_WAIT: begin
                state_next = ST_DONE;
                pmem_re_next = 1'b1;
            end
            ST_DONE: begin
                state_next = ST_IDLE;
                if (op_reg == OP_PMEM_RD || op_reg == OP_PMEM_WIDE_RD) begin
                    gpr_next[rd_reg] = pmem_rdata;
                end else if (dmem_re_reg) begin
                    gpr_next[rd_reg] = dmem_rdata;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_NOP;
            rd_reg <= 5'h00;
            for (int i = 0; i < 32; i++) begin
                gpr_reg[i] <= GPR_RESET;
            end
            stat_reg <= STAT_RESET;
            sp_reg <= SP_RESET;
            ext_reg <= EXT_RESET;
            dmem_addr_reg <= 16'h0000;
            dmem_re_reg <= 1'b0;
            dmem_we_reg <= 1'b0;
            dmem_wdata_reg <= 8'h00;
            pmem_addr_reg <= 24'h000000;
            pmem_re_reg <= 1'b0;
            io_addr_reg <= 5'h00;
            io_we_reg <= 1'b0;
            io_wdata_reg <= 8'h00;
            io_wmask_reg <= 8'h00;
            sleep_reg <= 1'b0;
            wdog_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            rd_reg <= rd_next;
            gpr_reg <= gpr_next;
            stat_reg <= stat_next;
            sp_reg <= sp_next;
            ext_reg <= ext_next;
            dmem_addr_reg <= dmem_addr_next;
            dmem_re_reg <= dmem_re_next;
            dmem_we_reg <= dmem_we_next;
            dmem_wdata_reg <= dmem_wdata_next;
            pmem_addr_reg <= pmem_addr_next;
            pmem_re_reg <= pmem_re_next;
            io_addr_reg <= io_addr_next;
            io_we_reg <= io_we_next;
            io_wdata_reg <= io_wdata_next;
            io_wmask_reg <= io_wmask_next;
            sleep_reg <= sleep_next;
            wdog_reg <= wdog_next;
        end
    end

    assign instr_ready = (state_reg == ST_IDLE);
    assign dmem_addr = dmem_addr_reg;
    assign dmem_re = dmem_re_reg;
    assign dmem_we = dmem_we_reg;
    assign dmem_wdata = dmem_wdata_reg;
    assign pmem_addr = pmem_addr_reg;
    assign pmem_re = pmem_re_reg;
    assign io_addr = io_addr_reg;
    assign io_we = io_we_reg;
    assign io_wdata = io_wdata_reg;
    assign io_wmask = io_wmask_reg;
    assign sleep_req = sleep_reg;
    assign wdog_req = wdog_reg;
    assign status = stat_reg;
    assign stack_ptr = sp_reg;
    assign ext_byte = ext_reg;
    assign peek_data = gpr_reg[peek_idx];

    // ==========================================================
    // Assertions
    logic [7:0] lat_val;
    assign lat_val = gpr_reg[rd_reg];

    property p_ld_postinc;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_LD_PTR && instr_ptr_mode == PTR_MODE_POSTINC |=>
            dmem_re && dmem_addr == $past(ptr_val) && !instr_ready ##1 instr_ready;
    endproperty
    a_ld_postinc: assert property (p_ld_postinc) else $error("post-increment load wrong");

    property p_ld_predec;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_LD_PTR && instr_ptr_mode == PTR_MODE_PREDEC |=>
            dmem_addr == $past(ptr_dec) ##1 lat_val == $past(dmem_rdata);
    endproperty
    a_ld_predec: assert property (p_ld_predec) else $error("pre-decrement load wrong");

    property p_ld_disp;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_LD_DISP |=>
            dmem_addr == $past(ptr_val) + {10'h000, $past(instr_disp)} ##1 status == $past(status, 2);
    endproperty
    a_ld_disp: assert property (p_ld_disp) else $error("displacement load wrong");

    property p_st_direct;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_ST_DIRECT |=>
            dmem_we && dmem_addr == $past(instr_addr) && dmem_wdata == $past(src_val);
    endproperty
    a_st_direct: assert property (p_st_direct) else $error("direct store wrong");

    property p_pmem_three;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && (instr_op == OP_PMEM_RD || instr_op == OP_PMEM_WIDE_RD) |=>
            (pmem_re && !instr_ready) [*2] ##1 instr_ready;
    endproperty
    a_pmem_three: assert property (p_pmem_three) else $error("program read not 3 cycles");

    property p_io_set;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_IO_SET |=> io_we && io_wmask == (8'h01 << $past(instr_bit)) && (io_wdata & io_wmask) != 8'h00;
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit set wrong");

    property p_lsl;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_LSL |=>
            lat_val == {$past(src_val[6:0]), 1'b0} && status[STAT_C] == $past(src_val[7]) && instr_ready;
    endproperty
    a_lsl: assert property (p_lsl) else $error("shift left wrong");

    property p_swap;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_SWAP |=> lat_val == {$past(src_val[3:0]), $past(src_val[7:4])} && $stable(status);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_push;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_PUSH |=> dmem_we && dmem_addr == $past(sp_reg) && stack_ptr == $past(sp_reg) - 16'h0001;
    endproperty
    a_push: assert property (p_push) else $error("push wrong");

    property p_sleep;
        @(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_SLEEP |=> sleep_req && instr_ready && $stable(status) ##1 !sleep_req;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep issue wrong");

    c_pop: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) take && instr_op == OP_POP);
    c_wide: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
        take && instr_op == OP_PMEM_WIDE_RD && instr_ptr_mode == PTR_MODE_POSTINC);
    c_t_store: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) take && instr_op == OP_BIT_TO_T);

endmodule : ctb_core

// *** verilog/ctb_pkg.sv ***
// Shared constants and types for the transfer and bit operation core
package ctb_pkg;

    // ==========================================================
    // Cycle counts per instruction class
    localparam int CYC_REG = 1;
    localparam int CYC_DMEM = 2;
    localparam int CYC_PMEM = 3;

    // ==========================================================
    // Pointer pairs in the register file
    localparam logic [4:0] PTR_BASE_X = 5'h1A;
    localparam logic [4:0] PTR_BASE_Y = 5'h1C;
    localparam logic [4:0] PTR_BASE_Z = 5'h1E;
    localparam logic [1:0] PTR_SEL_X = 2'h0;
    localparam logic [1:0] PTR_SEL_Y = 2'h1;

    // Pointer addressing modes
    localparam logic [1:0] PTR_MODE_PLAIN = 2'h0;
    localparam logic [1:0] PTR_MODE_POSTINC = 2'h1;
    localparam logic [1:0] PTR_MODE_PREDEC = 2'h2;

    // ==========================================================
    // Status register bit positions and reset values
    localparam int STAT_C = 0;
    localparam int STAT_Z = 1;
    localparam int STAT_N = 2;
    localparam int STAT_V = 3;
    localparam int STAT_S = 4;
    localparam int STAT_H = 5;
    localparam int STAT_T = 6;
    localparam int STAT_I = 7;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h21FF;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [7:0] GPR_RESET = 8'h00;

    // ==========================================================
    // Decoded operations
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_LDI = 5'h01,
        OP_LD_PTR = 5'h02,
        OP_LD_DISP = 5'h03,
        OP_LD_DIRECT = 5'h04,
        OP_ST_PTR = 5'h05,
        OP_ST_DISP = 5'h06,
        OP_ST_DIRECT = 5'h07,
        OP_PMEM_RD = 5'h08,
        OP_PMEM_WIDE_RD = 5'h09,
        OP_IO_SET = 5'h0A,
        OP_IO_CLR = 5'h0B,
        OP_LSL = 5'h0C,
        OP_LSR = 5'h0D,
        OP_ROL = 5'h0E,
        OP_ROR = 5'h0F,
        OP_SWAP = 5'h10,
        OP_BIT_TO_T = 5'h11,
        OP_T_TO_BIT = 5'h12,
        OP_FLAG_SET = 5'h13,
        OP_FLAG_CLR = 5'h14,
        OP_PUSH = 5'h15,
        OP_POP = 5'h16,
        OP_SLEEP = 5'h17,
        OP_WDOG = 5'h18
    } ctb_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } ctb_state_t;

endpackage : ctb_pkg

// *** verilog/ctb_bit_unit.sv ***
// Shift, rotate, swap and transfer-flag datapath
`timescale 1ns/100ps
module ctb_bit_unit
    import ctb_pkg::*;
(
    input wire ctb_op_t op,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    input wire logic t_in,
    input wire logic [2:0] bit_sel,
    output logic [7:0] result,
    output logic res_c,
    output logic res_z,
    output logic res_n,
    output logic res_v,
    output logic t_out
);

    // ==========================================================
    // Result and flags
    always_comb begin
        result = operand;
        res_c = carry_in;
        t_out = t_in;
        unique case (op)
            OP_LSL: begin
                result = {operand[6:0], 1'b0};
                res_c = operand[7];
            end
            OP_LSR: begin
                result = {1'b0, operand[7:1]};
                res_c = operand[0];
            end
            OP_ROL: begin
                result = {operand[6:0], carry_in};
                res_c = operand[7];
            end
            OP_ROR: begin
                result = {carry_in, operand[7:1]};
                res_c = operand[0];
            end
            OP_SWAP: result = {operand[3:0], operand[7:4]};
            OP_BIT_TO_T: t_out = operand[bit_sel];
            OP_T_TO_BIT: result[bit_sel] = t_in;
            default: result = operand;
        endcase
        res_n = result[7];
        res_z = (result == 8'h00);
        res_v = result[7] ^ res_c;
    end

endmodule : ctb_bit_unit

// *** dv/ctb_mem_model.sv ***
// Behavioural data, program and I/O space facing the core
`timescale 1ns/100ps
module ctb_mem_model (
    input wire logic ref_clk,
    input wire logic [15:0] dmem_addr,
    input wire logic dmem_re,
    input wire logic dmem_we,
    input wire logic [7:0] dmem_wdata,
    output logic [7:0] dmem_rdata,
    input wire logic [23:0] pmem_addr,
    input wire logic pmem_re,
    output logic [7:0] pmem_rdata,
    input wire logic [4:0] io_addr,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_wmask
);
    logic [7:0] dm [256];
    logic [7:0] io_q [32];
    initial for (int i = 0; i < 256; i++) dm[i] = i[7:0] ^ 8'hA5;
    initial for (int i = 0; i < 32; i++) io_q[i] = 8'h00;
    // Idle buses show inverted data so stale values never pass as a read
    assign dmem_rdata = dmem_re ? dm[dmem_addr[7:0]] : ~dm[dmem_addr[7:0]];
    assign pmem_rdata = pmem_addr[7:0] ^ (pmem_re ? 8'h3C : 8'hC3);
    always @(posedge ref_clk) begin
        if (dmem_we) dm[dmem_addr[7:0]] <= dmem_wdata;
        if (io_we) io_q[io_addr] <= (io_q[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
    end
endmodule : ctb_mem_model

// *** dv/ctb_core_tb.sv ***
// Testbench for the transfer and bit operation core
`timescale 1ns/100ps
module ctb_core_tb
    import ctb_pkg::*;
;
    logic ref_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, ext_wr_en = 1'b0;
    ctb_op_t instr_op = OP_NOP;
    logic [4:0] instr_reg = 5'h00, peek_idx = 5'h00, io_addr;
    logic [1:0] instr_ptr_sel = 2'h0, instr_ptr_mode = 2'h0;
    logic [2:0] instr_bit = 3'h0;
    logic [5:0] instr_disp = 6'h00;
    logic [15:0] instr_addr = 16'h0000, dmem_addr, stack_ptr;
    logic [7:0] instr_imm = 8'h00, ext_wr_data = 8'h00, dmem_wdata, dmem_rdata, pmem_rdata;
    logic [7:0] io_wdata, io_wmask, status, ext_byte, peek_data;
    logic instr_ready, dmem_re, dmem_we, pmem_re, io_we, sleep_req, wdog_req;
    logic [23:0] pmem_addr;
    int mismatches = 0, n_tests = 0, n_sleep = 0, n_wdog = 0;
    // Count control pulses in the settled half of each cycle
    always @(negedge ref_clk) begin
        if (sleep_req === 1'b1) n_sleep <= n_sleep + 1;
        if (wdog_req === 1'b1) n_wdog <= n_wdog + 1;
    end
    ctb_core DUT (.*);
    ctb_mem_model u_mem (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    // ==========================================================
    // Access tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ex(input ctb_op_t op, input logic [4:0] r, input logic [1:0] s, input logic [1:0] m,
        input logic [2:0] b, input logic [15:0] a, input logic [7:0] k, input int c);
        int n;
        @(negedge ref_clk);
        instr_op = op;
        instr_reg = r;
        instr_ptr_sel = s;
        instr_ptr_mode = m;
        instr_bit = b;
        instr_addr = a;
        instr_imm = k;
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
        n = 1;
        while (instr_ready !== 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n++;
        end
        chk(24'(n), 24'(c));
    endtask : ex
    task automatic pk(input logic [4:0] r, input logic [7:0] e);
        peek_idx = r;
        #1;
        chk(peek_data, e);
    endtask : pk
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // ==========================================================
    // Tests
    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        ex(OP_LDI, 5'h1A, '0, '0, '0, '0, 8'h10, 1);
        ex(OP_LDI, 5'h1B, '0, '0, '0, '0, 8'h00, 1);
        ex(OP_LDI, 5'h10, '0, '0, '0, '0, 8'h3C, 1);
        ex(OP_ST_PTR, 5'h10, PTR_SEL_X, PTR_MODE_POSTINC, '0, '0, '0, 2);
        chk(u_mem.dm[8'h10], 8'h3C);
        pk(5'h1A, 8'h11);
        ex(OP_LD_PTR, 5'h11, PTR_SEL_X, PTR_MODE_PREDEC, '0, '0, '0, 2);
        pk(5'h11, 8'h3C);
        pk(5'h1A, 8'h10);
        ex(OP_LD_PTR, 5'h12, PTR_SEL_X, PTR_MODE_POSTINC, '0, '0, '0, 2);
        pk(5'h12, 8'h3C);
        pk(5'h1A, 8'h11);
        ex(OP_LD_DIRECT, 5'h13, '0, '0, '0, 16'h0055, '0, 2);
        pk(5'h13, 8'hF0);
        chk(status, 8'h00);
        ex(OP_LDI, 5'h1C, '0, '0, '0, '0, 8'h20, 1);
        instr_disp = 6'h05;
        ex(OP_ST_DISP, 5'h13, PTR_SEL_Y, '0, '0, '0, '0, 2);
        chk(u_mem.dm[8'h25], 8'hF0);
        pk(5'h1C, 8'h20);
        ex(OP_LD_DISP, 5'h17, PTR_SEL_Y, '0, '0, '0, '0, 2);
        pk(5'h17, 8'hF0);
        pk(5'h1C, 8'h20);
        ex(OP_ST_DIRECT, 5'h10, '0, '0, '0, 16'h0030, '0, 2);
        chk(u_mem.dm[8'h30], 8'h3C);
        ex(OP_ST_PTR, 5'h10, PTR_SEL_Y, PTR_MODE_PREDEC, '0, '0, '0, 2);
        chk(u_mem.dm[8'h1F], 8'h3C);
        pk(5'h1C, 8'h1F);
        chk(status, 8'h00);
        $display("test data transfer done");
        ex(OP_SWAP, 5'h10, '0, '0, '0, '0, '0, 1);
        pk(5'h10, 8'hC3);
        ex(OP_LSL, 5'h10, '0, '0, '0, '0, '0, 1);
        pk(5'h10, 8'h86);
        chk(status, 8'h05);
        ex(OP_FLAG_SET, '0, '0, '0, 3'h7, '0, '0, 1);
        chk(status, 8'h85);
        ex(OP_BIT_TO_T, 5'h10, '0, '0, 3'h1, '0, '0, 1);
        chk(status, 8'hC5);
        ex(OP_T_TO_BIT, 5'h14, '0, '0, 3'h0, '0, '0, 1);
        pk(5'h14, 8'h01);
        ex(OP_LSR, 5'h13, '0, '0, '0, '0, '0, 1);
        pk(5'h13, 8'h78);
        chk(status, 8'hC0);
        ex(OP_ROL, 5'h13, '0, '0, '0, '0, '0, 1);
        pk(5'h13, 8'hF0);
        chk(status, 8'hCC);
        ex(OP_ROR, 5'h14, '0, '0, '0, '0, '0, 1);
        pk(5'h14, 8'h00);
        chk(status, 8'hCB);
        ex(OP_FLAG_CLR, '0, '0, '0, 3'h3, '0, '0, 1);
        chk(status, 8'hC3);
        $display("test bit ops done");
        ex(OP_PUSH, 5'h10, '0, '0, '0, '0, '0, 2);
        chk({u_mem.dm[8'hFF], stack_ptr}, 24'h8621FE);
        ex(OP_POP, 5'h15, '0, '0, '0, '0, '0, 2);
        pk(5'h15, 8'h86);
        chk(stack_ptr, 16'h21FF);
        @(negedge ref_clk);
        ext_wr_en = 1'b1;
        ext_wr_data = 8'h01;
        @(negedge ref_clk);
        ext_wr_en = 1'b0;
        ex(OP_LDI, 5'h1E, '0, '0, '0, '0, 8'hFF, 1);
        ex(OP_LDI, 5'h1F, '0, '0, '0, '0, 8'hFF, 1);
        ex(OP_PMEM_WIDE_RD, 5'h16, 2'h2, PTR_MODE_POSTINC, '0, '0, '0, 3);
        pk(5'h16, 8'hC3);
        pk(5'h1F, 8'h00);
        chk(ext_byte, 8'h02);
        chk(pmem_addr, 24'h01FFFF);
        ex(OP_PMEM_RD, 5'h18, 2'h2, PTR_MODE_POSTINC, '0, '0, '0, 3);
        pk(5'h18, 8'h3C);
        pk(5'h1E, 8'h01);
        chk(pmem_addr, 24'h000000);
        chk(ext_byte, 8'h02);
        ex(OP_IO_SET, '0, '0, '0, 3'h3, 16'h0005, '0, 2);
        chk(u_mem.io_q[5], 8'h08);
        ex(OP_IO_CLR, '0, '0, '0, 3'h3, 16'h0005, '0, 2);
        chk(u_mem.io_q[5], 8'h00);
        ex(OP_SLEEP, '0, '0, '0, '0, '0, '0, 1);
        ex(OP_WDOG, '0, '0, '0, '0, '0, '0, 1);
        @(negedge ref_clk);
        chk(24'(n_sleep), 24'h000001);
        chk(24'(n_wdog), 24'h000001);
        chk(status, 8'hC3);
        $display("test stack, program and control done");
        results();
    end
    initial begin
        #20us;
        mismatches++;
        results();
    end
endmodule : ctb_core_tb
